// ==== hw/mdmac_arbiter.sv ====
`timescale 1ns/100ps
module mdmac_arbiter (
  input  wire logic [7:0]  pend,
  input  wire logic [15:0] prio,
  output logic             found,
  output logic [2:0]       winner
);

  // ==========================================================================
  // Fixed two-stage arbitration.
  // Highest priority level wins; ties go to the lower index because the
  // scan runs downward and an equal or better level replaces the winner.
  always_comb begin
    logic [1:0] best;
    best   = mdmac_pkg::PL_LOW;
    found  = 1'b0;
    winner = 3'h0;
    for (int i = mdmac_pkg::NUM_CH - 1; i >= 0; i--) begin
      if (pend[i] && (!found || prio[2*i +: 2] >= best)) begin
        found  = 1'b1;
        best   = prio[2*i +: 2];
        winner = 3'(i);
      end
    end
  end

endmodule

// ==== hw/mdmac_pkg.sv ====
package mdmac_pkg;

  // ==========================================================================
  // Channel geometry and bus widths.
  localparam int NUM_CH    = 8;
  localparam int CH_W      = 3;
  localparam int ADDR_W    = 32;
  localparam int DATA_W    = 32;
  localparam int CNT_W     = 17;
  localparam int REG_IDX_W = 8;

  // ==========================================================================
  // Register map: each channel owns a block of CH_STRIDE byte addresses.
  localparam logic [REG_IDX_W-1:0] CH_STRIDE   = 8'h10;
  localparam logic [3:0]           OFS_CTRL    = 4'h0;
  localparam logic [3:0]           OFS_PBASE   = 4'h4;
  localparam logic [3:0]           OFS_MBASE   = 4'h8;
  localparam logic [3:0]           OFS_COUNT   = 4'hC;
  localparam logic [REG_IDX_W-1:0] ADDR_STATUS = 8'h80;
  localparam logic [REG_IDX_W-1:0] ADDR_CLEAR  = 8'h84;
  localparam logic [REG_IDX_W-1:0] ADDR_SWTRIG = 8'h88;

  // ==========================================================================
  // Control word field positions.
  localparam int F_EN     = 0;
  localparam int F_TCIE   = 1;
  localparam int F_HTIE   = 2;
  localparam int F_DIR    = 4;
  localparam int F_CIRCULAR_ENABLE   = 5;
  localparam int F_PINC   = 6;
  localparam int F_MINC   = 7;
  localparam int F_PSIZE  = 8;
  localparam int F_MSIZE  = 10;
  localparam int F_PL     = 12;
  localparam int F_M2M    = 14;
  localparam int CTRL_W   = 15;

  localparam logic [CTRL_W-1:0] CTRL_RESET  = 15'h0000;
  localparam logic [ADDR_W-1:0] ADDR_RESET  = 32'h0000_0000;
  localparam logic [CNT_W-1:0]  CNT_RESET   = 17'h0_0000;
  localparam logic [CNT_W-1:0]  CNT_MAX     = 17'h1_0000;

  // Transfer size codes.
  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_HALF = 2'h1;
  localparam logic [1:0] SZ_WORD = 2'h2;

  // Priority codes, higher code wins.
  localparam logic [1:0] PL_LOW = 2'h0;

  typedef enum logic [2:0] {
    MDMAC_IDLE,
    MDMAC_READ,
    MDMAC_WRITE,
    MDMAC_UPDATE,
    MDMAC_RELEASE
  } mdmac_state_t;

endpackage

// ==== hw/mdmac_top.sv ====
// Operation
// - Eight channels, each with its own peripheral request line.
// - A software trigger starts a channel without a peripheral request.
// - Each channel has a programmable priority of four levels.
// - Equal priority levels go to the lower channel index.
// - Source and destination sizes set separately; data packed or unpacked.
// - Circular mode lets a channel run repeatedly over one buffer.
// - Half-transfer and complete flags ORed into one interrupt per channel.
// - Transfers mem-mem (RAM only), periph-mem, mem-periph, periph-periph.
// - Programmed count may reach 65536 items.
// - Controller is a bus master sharing the bus by round robin.
// - Processor stalls only when both target the same slave.
// - Serve by priority; acknowledge as the peripheral access happens (acked in the read phase, either direction).
// - Acknowledge holds until the request falls, then drops.
// - Each transfer reads, then writes, then updates the count.
// - Current addresses start at the programmed base addresses.
// - The remaining count drops by one after each transfer.
// - Non-circular channel serves nothing once its count is zero.
// - Circular channel, unless memory-to-memory, reloads count and addresses after the last transfer.
// - Memory-to-memory channel starts when enabled, stops at zero count.
`timescale 1ns/100ps
module mdmac_top (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [31:0]      reg_rdata,
  input  wire logic [7:0]  periph_req,
  output logic [7:0]       periph_ack,
  output logic [7:0]       ch_irq,
  output logic             bus_req,
  input  wire logic        bus_gnt,
  output logic             bus_we,
  output logic [31:0]      bus_addr,
  output logic [1:0]       bus_size,
  output logic [31:0]      bus_wdata,
  input  wire logic [31:0] bus_rdata,
  input  wire logic        bus_done
);

  localparam int N = mdmac_pkg::NUM_CH;

  // ==========================================================================
  // Channel registers.
  logic [mdmac_pkg::CTRL_W-1:0] ctrl_reg  [N];
  logic [31:0]                  pbase_reg [N];
  logic [31:0]                  mbase_reg [N];
  logic [16:0]                  init_reg  [N];
  logic [16:0]                  cnt_reg   [N];
  logic [31:0]                  pcur_reg  [N];
  logic [31:0]                  mcur_reg  [N];
  logic [N-1:0]                 tc_reg;
  logic [N-1:0]                 ht_reg;
  logic [N-1:0]                 sw_reg;
  logic [N-1:0]                 ack_reg;
  logic [N-1:0]                 req_s1_reg, req_s2_reg, req_s3_reg;
  logic [N-1:0]                 req_lvl_reg;

  mdmac_pkg::mdmac_state_t state_reg;
  logic [2:0]              cur_reg;
  logic [31:0]             data_reg;
  logic [31:0]             rdata_reg;

  // ==========================================================================
  // Decode helpers.
  function automatic logic [31:0] size_step(input logic [1:0] sz);
    unique case (sz)
      mdmac_pkg::SZ_HALF: size_step = 32'h0000_0002;
      mdmac_pkg::SZ_WORD: size_step = 32'h0000_0004;
      default:            size_step = 32'h0000_0001;
    endcase
  endfunction

  // Narrow data is zero extended; wider source data is truncated.
  function automatic logic [31:0] fit(input logic [31:0] d,
                                      input logic [1:0]  sz);
    unique case (sz)
      mdmac_pkg::SZ_BYTE: fit = {24'h00_0000, d[7:0]};
      mdmac_pkg::SZ_HALF: fit = {16'h0000, d[15:0]};
      default:            fit = d;
    endcase
  endfunction

  function automatic logic is_ch_reg(input logic [7:0] a,
                                     input logic [3:0] ofs,
                                     input int         ch);
    is_ch_reg = (a == 8'(ch * 16) + {4'h0, ofs});
  endfunction

  // ==========================================================================
  // Request pins pass three flops; a level counts once stages two and three
  // agree, which filters a single-cycle glitch on the pin.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      req_s1_reg  <= 8'h00;
      req_s2_reg  <= 8'h00;
      req_s3_reg  <= 8'h00;
      req_lvl_reg <= 8'h00;
    end else begin
      req_s1_reg <= periph_req;
      req_s2_reg <= req_s1_reg;
      req_s3_reg <= req_s2_reg;
      for (int i = 0; i < N; i++) begin
        if (req_s2_reg[i] == req_s3_reg[i]) begin
          req_lvl_reg[i] <= req_s3_reg[i];
        end
      end
    end
  end

  // ==========================================================================
  // Pending requests and arbitration.
  logic [N-1:0] pend;
  logic [15:0]  prio;
  logic         found;
  logic [2:0]   winner;

  // A channel is eligible only when enabled with work left and its ack low.
  always_comb begin
    for (int i = 0; i < N; i++) begin
      pend[i] = ctrl_reg[i][mdmac_pkg::F_EN] && cnt_reg[i] != 17'h0_0000 &&
                !ack_reg[i] &&
                (req_lvl_reg[i] || sw_reg[i] ||
                 ctrl_reg[i][mdmac_pkg::F_M2M]);
      prio[2*i +: 2] = ctrl_reg[i][mdmac_pkg::F_PL +: 2];
    end
  end

  mdmac_arbiter u_arb (
    .pend   (pend),
    .prio   (prio),
    .found  (found),
    .winner (winner)
  );

  // ==========================================================================
  // Transfer sequencer; a new winner is taken only in IDLE.
  logic [mdmac_pkg::CTRL_W-1:0] cc;
  logic                         m2p;
  logic [1:0]                   src_sz, dst_sz;
  logic [31:0]                  src_addr, dst_addr;

  always_comb begin
    cc       = ctrl_reg[cur_reg];
    m2p      = cc[mdmac_pkg::F_DIR];
    src_sz   = m2p ? cc[mdmac_pkg::F_MSIZE +: 2] : cc[mdmac_pkg::F_PSIZE +: 2];
    dst_sz   = m2p ? cc[mdmac_pkg::F_PSIZE +: 2] : cc[mdmac_pkg::F_MSIZE +: 2];
    src_addr = m2p ? mcur_reg[cur_reg] : pcur_reg[cur_reg];
    dst_addr = m2p ? pcur_reg[cur_reg] : mcur_reg[cur_reg];
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_reg <= mdmac_pkg::MDMAC_IDLE;
      cur_reg   <= 3'h0;
      data_reg  <= 32'h0000_0000;
    end else begin
      unique case (state_reg)
        mdmac_pkg::MDMAC_IDLE: begin
          if (found) begin
            cur_reg   <= winner;
            state_reg <= mdmac_pkg::MDMAC_READ;
          end
        end
        mdmac_pkg::MDMAC_READ: begin
          if (bus_gnt && bus_done) begin
            data_reg  <= fit(bus_rdata, src_sz);
            state_reg <= mdmac_pkg::MDMAC_WRITE;
          end
        end
        mdmac_pkg::MDMAC_WRITE: begin
          if (bus_gnt && bus_done) begin
            state_reg <= mdmac_pkg::MDMAC_UPDATE;
          end
        end
        mdmac_pkg::MDMAC_UPDATE: begin
          state_reg <= mdmac_pkg::MDMAC_IDLE;
        end
        default: begin
          state_reg <= mdmac_pkg::MDMAC_IDLE;
        end
      endcase
    end
  end

  // Bus master outputs; the external round-robin matrix grants the bus.
  always_comb begin
    bus_req   = (state_reg == mdmac_pkg::MDMAC_READ) ||
                (state_reg == mdmac_pkg::MDMAC_WRITE);
    bus_we    = (state_reg == mdmac_pkg::MDMAC_WRITE);
    bus_addr  = bus_we ? dst_addr : src_addr;
    bus_size  = bus_we ? dst_sz : src_sz;
    bus_wdata = fit(data_reg, dst_sz);
  end

  // ==========================================================================
  // Acknowledge rises in the read phase, even when the peripheral is the write target, and falls after the
  // synchronised request has dropped.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ack_reg <= 8'h00;
    end else begin
      for (int i = 0; i < N; i++) begin
        if (state_reg == mdmac_pkg::MDMAC_READ && cur_reg == 3'(i) &&
            !ctrl_reg[i][mdmac_pkg::F_M2M] && !sw_reg[i] &&
            req_lvl_reg[i]) begin
          ack_reg[i] <= 1'b1;
        end else if (!req_lvl_reg[i]) begin
          ack_reg[i] <= 1'b0;
        end
      end
    end
  end

  assign periph_ack = ack_reg;

  // ==========================================================================
  // Register writes, address and count update, flags.
  logic upd;
  assign upd = (state_reg == mdmac_pkg::MDMAC_UPDATE);

  generate
    for (genvar g = 0; g < N; g++) begin : g_ch
      logic last;
      logic [16:0] cnt_dec;
      assign cnt_dec = cnt_reg[g] - 17'h0_0001;
      assign last    = upd && cur_reg == 3'(g) && cnt_reg[g] == 17'h0_0001;

      always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
          ctrl_reg[g]  <= mdmac_pkg::CTRL_RESET;
          pbase_reg[g] <= mdmac_pkg::ADDR_RESET;
          mbase_reg[g] <= mdmac_pkg::ADDR_RESET;
          init_reg[g]  <= mdmac_pkg::CNT_RESET;
        end else if (reg_wr) begin
          if (is_ch_reg(reg_addr, mdmac_pkg::OFS_CTRL, g)) begin
            ctrl_reg[g] <= reg_wdata[mdmac_pkg::CTRL_W-1:0];
          end
          if (is_ch_reg(reg_addr, mdmac_pkg::OFS_PBASE, g)) begin
            pbase_reg[g] <= reg_wdata;
          end
          if (is_ch_reg(reg_addr, mdmac_pkg::OFS_MBASE, g)) begin
            mbase_reg[g] <= reg_wdata;
          end
          if (is_ch_reg(reg_addr, mdmac_pkg::OFS_COUNT, g) &&
              !ctrl_reg[g][mdmac_pkg::F_EN]) begin
            // Zero programs the full 65536.
            init_reg[g] <= (reg_wdata[15:0] == 16'h0000) ?
                           mdmac_pkg::CNT_MAX : {1'b0, reg_wdata[15:0]};
          end
        end
      end

      // Enabling (re)loads counter and current addresses from the bases.
      always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
          cnt_reg[g]  <= mdmac_pkg::CNT_RESET;
          pcur_reg[g] <= mdmac_pkg::ADDR_RESET;
          mcur_reg[g] <= mdmac_pkg::ADDR_RESET;
        end else if (!ctrl_reg[g][mdmac_pkg::F_EN]) begin
          cnt_reg[g]  <= init_reg[g];
          pcur_reg[g] <= pbase_reg[g];
          mcur_reg[g] <= mbase_reg[g];
        end else if (last && ctrl_reg[g][mdmac_pkg::F_CIRCULAR_ENABLE] &&
                     !ctrl_reg[g][mdmac_pkg::F_M2M]) begin
          cnt_reg[g]  <= init_reg[g];
          pcur_reg[g] <= pbase_reg[g];
          mcur_reg[g] <= mbase_reg[g];
        end else if (upd && cur_reg == 3'(g)) begin
          cnt_reg[g] <= cnt_dec;
          if (ctrl_reg[g][mdmac_pkg::F_PINC]) begin
            pcur_reg[g] <= pcur_reg[g] +
                           size_step(ctrl_reg[g][mdmac_pkg::F_PSIZE +: 2]);
          end
          if (ctrl_reg[g][mdmac_pkg::F_MINC]) begin
            mcur_reg[g] <= mcur_reg[g] +
                           size_step(ctrl_reg[g][mdmac_pkg::F_MSIZE +: 2]);
          end
        end
      end

      // Flags: a hardware set wins over a software clear in the same cycle.
      always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
          tc_reg[g] <= 1'b0;
          ht_reg[g] <= 1'b0;
          sw_reg[g] <= 1'b0;
        end else begin
          if (last) begin
            tc_reg[g] <= 1'b1;
          end else if (reg_wr && reg_addr == mdmac_pkg::ADDR_CLEAR &&
                       reg_wdata[g]) begin
            tc_reg[g] <= 1'b0;
          end
          if (upd && cur_reg == 3'(g) && cnt_dec == (init_reg[g] >> 1)) begin
            ht_reg[g] <= 1'b1;
          end else if (reg_wr && reg_addr == mdmac_pkg::ADDR_CLEAR &&
                       reg_wdata[8+g]) begin
            ht_reg[g] <= 1'b0;
          end
          // A software trigger is consumed by one transfer.
          if (reg_wr && reg_addr == mdmac_pkg::ADDR_SWTRIG &&
              reg_wdata[g]) begin
            sw_reg[g] <= 1'b1;
          end else if (upd && cur_reg == 3'(g)) begin
            sw_reg[g] <= 1'b0;
          end
        end
      end

      assign ch_irq[g] = (tc_reg[g] && ctrl_reg[g][mdmac_pkg::F_TCIE]) ||
        (ht_reg[g] && ctrl_reg[g][mdmac_pkg::F_HTIE]);
    end
  endgenerate

  // ==========================================================================
  // Read port: data in the cycle after the read strobe; unmapped reads zero.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rdata_reg <= 32'h0000_0000;
    end else if (reg_rd) begin
      rdata_reg <= 32'h0000_0000;
      if (reg_addr == mdmac_pkg::ADDR_STATUS) begin
        rdata_reg <= {16'h0000, ht_reg, tc_reg};
      end
      for (int i = 0; i < N; i++) begin
        if (is_ch_reg(reg_addr, mdmac_pkg::OFS_CTRL, i)) begin
          rdata_reg <= {17'h0_0000, ctrl_reg[i]};
        end
        if (is_ch_reg(reg_addr, mdmac_pkg::OFS_PBASE, i)) begin
          rdata_reg <= pbase_reg[i];
        end
        if (is_ch_reg(reg_addr, mdmac_pkg::OFS_MBASE, i)) begin
          rdata_reg <= mbase_reg[i];
        end
        if (is_ch_reg(reg_addr, mdmac_pkg::OFS_COUNT, i)) begin
          rdata_reg <= {15'h0000, cnt_reg[i]};
        end
      end
    end else begin
      rdata_reg <= 32'h0000_0000;
    end
  end

  assign reg_rdata = rdata_reg;

endmodule

// ==== verif/mdmac_chk_sva.sv ====
`timescale 1ns/100ps
module mdmac_chk (
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic        reg_wr,
  input wire logic [7:0]  periph_req,
  input wire logic [7:0]  periph_ack,
  input wire logic [7:0]  ch_irq,
  input wire logic        bus_req,
  input wire logic        bus_gnt,
  input wire logic        bus_we,
  input wire logic [31:0] bus_addr,
  input wire logic [1:0]  bus_size,
  input wire logic [31:0] bus_wdata,
  input wire logic        bus_done
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  // ==========================================================================
  // Phases of one transfer on the system bus.
  sequence s_rd_done;
    bus_req && !bus_we && bus_gnt && bus_done;
  endsequence
  sequence s_wr_done;
    bus_req && bus_we && bus_gnt && bus_done;
  endsequence
  sequence s_wait;
    bus_req && !(bus_gnt && bus_done);
  endsequence

  property p_rd_then_wr;
    s_rd_done |=> bus_req && bus_we;
  endproperty
  a_rd_then_wr: assert property (p_rd_then_wr)
    else $error("write phase did not follow a finished read");

  // The count update and the arbiter pick keep the bus quiet for two cycles.
  property p_wr_then_gap;
    s_wr_done |=> !bus_req [*2];
  endproperty
  a_wr_then_gap: assert property (p_wr_then_gap)
    else $error("bus request too soon after a finished write");

  property p_hold;
    s_wait |=> bus_req && $stable(bus_addr) && $stable(bus_we)
               && $stable(bus_size);
  endproperty
  a_hold: assert property (p_hold)
    else $error("bus request changed before it was completed");

  property p_wdata_hold;
    bus_req && bus_we && !(bus_gnt && bus_done) |=> $stable(bus_wdata);
  endproperty
  a_wdata_hold: assert property (p_wdata_hold)
    else $error("write data changed while the write waited");

  property p_start_read;
    $rose(bus_req) |-> !bus_we;
  endproperty
  a_start_read: assert property (p_start_read)
    else $error("transfer did not open with a read");

  property p_size_legal;
    bus_req |-> bus_size != 2'h3;
  endproperty
  a_size_legal: assert property (p_size_legal)
    else $error("illegal bus size code");

  // ==========================================================================
  // Peripheral handshake and interrupt causes.
  property p_ack_hold;
    ($past(periph_ack) & ~periph_ack & $past(periph_req)) == 8'h00;
  endproperty
  a_ack_hold: assert property (p_ack_hold)
    else $error("acknowledge dropped while the request was high");

  property p_ack_at_read;
    (periph_ack & ~$past(periph_ack)) != 8'h00
      |-> $past(bus_req && !bus_we);
  endproperty
  a_ack_at_read: assert property (p_ack_at_read)
    else $error("acknowledge rose outside a read phase");

  property p_irq_cause;
    (ch_irq & ~$past(ch_irq)) != 8'h00
      |-> $past(bus_req && bus_we && bus_gnt && bus_done)
       || $past(bus_req && bus_we && bus_gnt && bus_done, 2)
       || $past(reg_wr) || $past(reg_wr, 2);
  endproperty
  a_irq_cause: assert property (p_irq_cause)
    else $error("interrupt rose without a transfer or a write");
endmodule

// ==== verif/mdmac_far.sv ====
`timescale 1ns/100ps
module mdmac_far #(
  parameter logic [31:0] RD_XOR = 32'hA5A5_0000
) (
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic        slow,
  input wire logic [7:0]  fire,
  input wire logic [7:0]  periph_ack,
  output logic [7:0]      periph_req,
  input wire logic        bus_req,
  input wire logic        bus_we,
  input wire logic [31:0] bus_addr,
  output logic            bus_gnt,
  output logic            bus_done,
  output logic [31:0]     bus_rdata
);
  logic [1:0]  wait_reg;
  logic [31:0] noise_reg;
  logic        ok;

  // ==========================================================================
  // Bus slave: answers at once, or after two wait cycles when slow.
  assign ok        = bus_req && (!slow || wait_reg == 2'h2);
  assign bus_gnt   = ok;
  assign bus_done  = ok;
  // Outside a finished read the data lines churn, so stale data shows up.
  assign bus_rdata = (ok && !bus_we) ? (bus_addr ^ RD_XOR) : noise_reg;

  // Wait counter and churning pattern.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wait_reg  <= 2'h0;
      noise_reg <= 32'h1357_9BDF;
    end else begin
      wait_reg  <= (!bus_req || ok) ? 2'h0 : wait_reg + 2'h1;
      noise_reg <= noise_reg + 32'h9E37_79B9;
    end
  end

  // Peripherals: a fire pulse raises the request, acknowledge drops it.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      periph_req <= 8'h00;
    end else begin
      periph_req <= (periph_req | fire) & ~periph_ack;
    end
  end
endmodule

// ==== verif/mdmac_tb_top.sv ====
`timescale 1ns/100ps
module mdmac_tb_top;
  localparam logic [31:0] RD_XOR = 32'hA5A5_0000;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic [7:0]  periph_req, periph_ack, ch_irq, fire = 8'h00;
  logic        bus_req, bus_gnt, bus_we, bus_done, slow = 1'b0;
  logic [31:0] bus_addr, bus_wdata, bus_rdata, seed = 32'h0000_0041;
  logic [31:0] pb, mb, tmp;
  logic [1:0]  bus_size;
  logic        rd_d = 1'b0;
  logic [63:0] ew;
  logic [31:0] exp_rd[$];
  logic [63:0] exp_wr[$];
  logic [2:0]  ord[5] = '{3'h4, 3'h5, 3'h1, 3'h3, 3'h6};
  logic [1:0]  lvl[5] = '{2'h3, 2'h2, 2'h1, 2'h0, 2'h0};
  int          num_errors = 0;
  int          n_compared = 0;

  always #5 clk_sys = ~clk_sys;

  mdmac_top i_dut (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .periph_req(periph_req), .periph_ack(periph_ack),
    .ch_irq(ch_irq), .bus_req(bus_req), .bus_gnt(bus_gnt), .bus_we(bus_we),
    .bus_addr(bus_addr), .bus_size(bus_size), .bus_wdata(bus_wdata),
    .bus_rdata(bus_rdata), .bus_done(bus_done));

  mdmac_far #(.RD_XOR(RD_XOR)) i_far (.clk_sys(clk_sys), .rst(rst),
    .slow(slow), .fire(fire), .periph_ack(periph_ack),
    .periph_req(periph_req), .bus_req(bus_req), .bus_we(bus_we),
    .bus_addr(bus_addr), .bus_gnt(bus_gnt), .bus_done(bus_done),
    .bus_rdata(bus_rdata));

  // ==========================================================================
  // Helpers.
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_compared++;
    if (e !== g) begin
      $display("BAD %s exp %h got %h", nm, e, g);
      num_errors++;
    end
  endtask

  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    xs = s ^ (s << 5);
  endfunction

  // Random word-aligned bases; the top nibble keeps the two apart.
  task automatic new_bases;
    seed = xs(seed);
    pb = {4'h4, seed[27:4], 4'h0};
    seed = xs(seed);
    mb = {4'h2, seed[27:4], 4'h0};
  endtask

  function automatic logic [31:0] mk(input logic dir, circular_enable, m2m,
                                     input logic [1:0] psz, msz, pl);
    mk = 32'h0000_00C7 | (32'(dir) << mdmac_pkg::F_DIR)
       | (32'(circular_enable) << mdmac_pkg::F_CIRCULAR_ENABLE) | (32'(m2m) << mdmac_pkg::F_M2M)
       | (32'(psz) << mdmac_pkg::F_PSIZE) | (32'(msz) << mdmac_pkg::F_MSIZE)
       | (32'(pl) << mdmac_pkg::F_PL);
  endfunction

  // Register bus master; a gap cycle follows every strobe.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_rd.push_back(e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(posedge clk_sys);
  endtask

  // Switched off first: a count write is ignored while it runs.
  task automatic cfg(input logic [2:0] c, input logic [31:0] n, ctl);
    wr({1'b0, c, mdmac_pkg::OFS_CTRL}, 32'h0000_0000);
    wr({1'b0, c, mdmac_pkg::OFS_PBASE}, pb);
    wr({1'b0, c, mdmac_pkg::OFS_MBASE}, mb);
    wr({1'b0, c, mdmac_pkg::OFS_COUNT}, n);
    wr({1'b0, c, mdmac_pkg::OFS_CTRL}, ctl);
  endtask

  task automatic settle;
    int i;
    i = 0;
    while ((exp_wr.size() != 0 || periph_ack !== 8'h00 || bus_req !== 1'b0)
           && i < 400) begin
      @(posedge clk_sys);
      i++;
    end
    if (i == 400) begin
      $display("BAD settle exp %h got %h", 32'h0, exp_wr.size());
      num_errors++;
    end
    repeat (4) @(posedge clk_sys);
  endtask

  task automatic fire_ch(input logic [7:0] m);
    fire <= m;
    @(posedge clk_sys);
    fire <= 8'h00;
    @(posedge clk_sys);
    settle();
  endtask

  // ==========================================================================
  // Monitor: read data and bus writes are matched against the notes.
  always @(posedge clk_sys) rd_d <= reg_rd;
  always @(negedge clk_sys) begin
    if (rd_d) chk("reg_rdata", exp_rd.pop_front(), reg_rdata);
    if (!rst && bus_req && bus_we && bus_gnt && bus_done) begin
      ew = (exp_wr.size() != 0) ? exp_wr.pop_front() : 64'hx;
      chk("bus_addr", ew[63:32], bus_addr);
      chk("bus_wdata", ew[31:0], bus_wdata);
      chk("bus_size", 32'(mdmac_pkg::SZ_WORD), {30'h0, bus_size});
    end
  end

  // Watchdog: the whole sequence needs well under a tenth of this.
  initial begin
    repeat (40000) @(posedge clk_sys);
    num_errors++;
    test_done();
  end

  // ==========================================================================
  // Test sequence.
  initial begin
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    rd({1'b0, 3'h2, mdmac_pkg::OFS_CTRL}, 32'h0000_0000);
    rd({1'b0, 3'h2, mdmac_pkg::OFS_COUNT}, 32'h0000_0000);
    rd(mdmac_pkg::ADDR_STATUS, 32'h0000_0000);
    rd(8'hF0, 32'h0000_0000);
    wr({1'b0, 3'h2, mdmac_pkg::OFS_COUNT}, 32'h0000_0000);
    rd({1'b0, 3'h2, mdmac_pkg::OFS_COUNT}, 32'h0001_0000);
    $display("test reset values done");
    pb = 32'h4000_0010;
    mb = 32'h2000_0100;
    cfg(3'h2, 32'h0000_0002, mk(0, 0, 0, mdmac_pkg::SZ_WORD,
        mdmac_pkg::SZ_WORD, mdmac_pkg::PL_LOW));
    for (int i = 0; i < 2; i++) begin
      exp_wr.push_back({mb + 32'(4 * i), (pb + 32'(4 * i)) ^ RD_XOR});
      fire_ch(8'h04);
    end
    rd({1'b0, 3'h2, mdmac_pkg::OFS_COUNT}, 32'h0000_0000);
    rd(mdmac_pkg::ADDR_STATUS, 32'h0000_0404);
    chk("ch_irq", 32'h0000_0004, {24'h0, ch_irq});
    fire_ch(8'h04);
    repeat (40) @(posedge clk_sys);
    chk("periph_ack", 32'h0000_0000, {24'h0, periph_ack});
    wr(mdmac_pkg::ADDR_CLEAR, 32'h0000_0404);
    rd(mdmac_pkg::ADDR_STATUS, 32'h0000_0000);
    $display("test peripheral transfer done");
    slow <= 1'b1;
    for (int k = 0; k < 5; k++) begin
      new_bases();
      cfg(ord[k], 32'h0000_0001, mk(0, 0, 0, mdmac_pkg::SZ_WORD,
          mdmac_pkg::SZ_WORD, lvl[k]));
      exp_wr.push_back({mb, pb ^ RD_XOR});
    end
    fire_ch(8'h7A);
    $display("test priority done");
    new_bases();
    exp_wr.push_back({pb, mb ^ RD_XOR});
    cfg(3'h6, 32'h0000_0001, mk(1, 0, 0, mdmac_pkg::SZ_WORD,
        mdmac_pkg::SZ_WORD, mdmac_pkg::PL_LOW));
    wr(mdmac_pkg::ADDR_SWTRIG, 32'h0000_0040);
    settle();
    $display("test software trigger done");
    new_bases();
    for (int i = 0; i < 3; i++)
      exp_wr.push_back({mb + 32'(4 * i), (pb + 32'(4 * i)) ^ RD_XOR});
    cfg(3'h7, 32'h0000_0003, mk(0, 0, 1, mdmac_pkg::SZ_WORD,
        mdmac_pkg::SZ_WORD, mdmac_pkg::PL_LOW));
    settle();
    rd({1'b0, 3'h7, mdmac_pkg::OFS_COUNT}, 32'h0000_0000);
    new_bases();
    tmp = pb ^ RD_XOR;
    exp_wr.push_back({mb, 24'h00_0000, tmp[7:0]});
    cfg(3'h3, 32'h0000_0001, mk(0, 0, 1, mdmac_pkg::SZ_BYTE,
        mdmac_pkg::SZ_WORD, mdmac_pkg::PL_LOW));
    settle();
    $display("test memory to memory done");
    slow <= 1'b0;
    new_bases();
    cfg(3'h0, 32'h0000_0002, mk(0, 1, 0, mdmac_pkg::SZ_WORD,
        mdmac_pkg::SZ_WORD, mdmac_pkg::PL_LOW));
    for (int i = 0; i < 3; i++) begin
      tmp = 32'(4 * (i % 2));
      exp_wr.push_back({mb + tmp, (pb + tmp) ^ RD_XOR});
      fire_ch(8'h01);
    end
    rd({1'b0, 3'h0, mdmac_pkg::OFS_COUNT}, 32'h0000_0001);
    $display("test circular done");
    test_done();
  end
endmodule

bind mdmac_top mdmac_chk i_chk (.clk_sys(clk_sys), .rst(rst),
  .reg_wr(reg_wr), .periph_req(periph_req), .periph_ack(periph_ack),
  .ch_irq(ch_irq), .bus_req(bus_req), .bus_gnt(bus_gnt), .bus_we(bus_we),
  .bus_addr(bus_addr), .bus_size(bus_size), .bus_wdata(bus_wdata),
  .bus_done(bus_done));
